// ===== dac_cmd_port.sv
// Serial slave command port with double-buffered DAC channel registers
`include "dac_port_consts.svh"
`default_nettype none
module dac_cmd_port #(
  parameter int FDEPTH = 2
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Board pins
  input wire dac_port_pkg::pins_t pins_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Channel state
  output logic [7:0][15:0] dac_code_out,
  output logic [7:0] pwrdn_mode_hi_out,
  output logic [7:0] pwrdn_mode_lo_out
);
  import dac_port_pkg::*;

  localparam int AW = (FDEPTH > 1) ? $clog2(FDEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(FDEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(FDEPTH);

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  typedef struct packed {
    pins_t s1;
    pins_t s2;
    pins_t s3;
    logic [1:0] strap;
    bus_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [1:0] nb;
    logic rw;
    logic [15:0] fr;
    logic [2:0] ptr;
    logic lo;
    logic oe;
    logic sda_o;
    logic [FDEPTH-1:0][23:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fc;
    logic [7:0][15:0] inp;
    logic [7:0][15:0] dac;
    logic [15:0] pd;
    logic [7:0] mask;
  } state_t;

  state_t q, d;
  logic scl_r, scl_f, start, stop, ld_fall, full, pop;
  logic [7:0] tx;
  frame_t head;

  // Only the second synchroniser stage and its delayed copy are read
  assign scl_r = q.s2.scl & ~q.s3.scl;
  assign scl_f = ~q.s2.scl & q.s3.scl;
  assign start = q.s2.scl & q.s3.scl & q.s3.sda & ~q.s2.sda;
  assign stop = q.s2.scl & q.s3.scl & ~q.s3.sda & q.s2.sda;
  assign ld_fall = q.s3.load_strobe_n & ~q.s2.load_strobe_n;
  assign full = (q.fc == FULL);
  // Executor stalls for a strobe edge, so a pending frame waits one cycle
  assign pop = (q.fc != '0) && !ld_fall;
  assign head = frame_t'(q.mem[q.rp]);
  assign tx = q.lo ? q.inp[q.ptr][7:0] : q.inp[q.ptr][15:8];

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  always_comb begin
    d = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.strap = {q.s2.addr_strap_high, q.s2.addr_strap_low};
    // Serial engine; start and stop win over any bit in flight
    if (start) begin
      d.st = ST_ADDR;
      d.cnt = '0;
      d.oe = 1'b0;
    end else if (stop) begin
      d.st = ST_IDLE;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        ST_ADDR, ST_WR: begin
          if (scl_r) begin
            d.sh = {q.sh[6:0], q.s2.sda};
            d.cnt = q.cnt + 4'h1;
          end
          if (scl_f && q.cnt == `BITS_PER_BYTE) begin
            d.cnt = '0;
            if (q.st == ST_ADDR) begin
              if (q.sh[7:1] == {`SLAVE_ADDR_HI, q.strap}) begin
                d.st = ST_ACKA;
                d.oe = 1'b1;
                d.rw = q.sh[0];
              end else begin
                d.st = ST_SKIP;
              end
            end else begin
              d.st = ST_ACKW;
              d.oe = 1'b1;
              if (q.nb == `BYTE_CMD) begin
                d.fr[15:8] = q.sh;
                d.ptr = q.sh[3] ? `CHAN_ZERO : q.sh[2:0];
                d.lo = 1'b0;
              end else if (q.nb == `BYTE_HIGH) begin
                d.fr[7:0] = q.sh;
              end else if (q.nb == `BYTE_LOW) begin
                // A full buffer refuses the frame with a NACK
                d.oe = !full;
                if (!full) begin
                  d.mem[q.wp] = {q.fr, q.sh};
                  d.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
                end
              end else begin
                d.oe = 1'b0;
              end
              if (q.nb != `BYTE_EXTRA) begin
                d.nb = q.nb + 2'h1;
              end
            end
          end
        end
        ST_ACKA: begin
          if (scl_f) begin
            d.nb = `BYTE_CMD;
            if (q.rw) begin
              d.st = ST_RD;
              d.sh = tx;
              d.oe = ~tx[7];
              d.cnt = `FIRST_TX_BIT;
            end else begin
              d.st = ST_WR;
              d.oe = 1'b0;
            end
          end
        end
        ST_ACKW: begin
          if (scl_f) begin
            d.st = ST_WR;
            d.oe = 1'b0;
          end
        end
        ST_RD: begin
          if (scl_f) begin
            if (q.cnt == `BITS_PER_BYTE) begin
              d.oe = 1'b0;
              d.st = ST_ACKR;
              d.lo = ~q.lo;
              if (q.lo) begin
                d.ptr = q.ptr + 3'h1;
              end
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.oe = ~q.sh[6];
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        ST_ACKR: begin
          if (scl_r && q.s2.sda) begin
            d.st = ST_SKIP;
          end else if (scl_f) begin
            d.st = ST_RD;
            d.sh = tx;
            d.oe = ~tx[7];
            d.cnt = `FIRST_TX_BIT;
          end
        end
        default: begin
          d.oe = 1'b0;
        end
      endcase
    end
    // Executor; a strobe edge takes the cycle and the frame waits
    if (ld_fall) begin
      for (int i = 0; i < 8; i++) begin
        if (!q.mask[i]) begin
          d.dac[i] = q.inp[i];
        end
      end
    end else if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
      case (head.command_code)
        `CMD_WR_IN: begin
          if (!head.chan[3]) begin
            d.inp[head.chan[2:0]] = head.data;
            if (!q.s2.load_strobe_n && !q.mask[head.chan[2:0]]) begin
              d.dac[head.chan[2:0]] = head.data;
            end
          end
        end
        `CMD_UPDATE: begin
          if (!head.chan[3]) begin
            d.dac[head.chan[2:0]] = q.inp[head.chan[2:0]];
          end
        end
        `CMD_WR_UPD: begin
          if (!head.chan[3]) begin
            d.inp[head.chan[2:0]] = head.data;
            d.dac[head.chan[2:0]] = head.data;
          end
        end
        `CMD_PWRDN: begin
          d.pd = head.data;
        end
        `CMD_MASK: begin
          d.mask = head.data[7:0];
        end
        `CMD_ALL_IN: begin
          for (int i = 0; i < 8; i++) begin
            d.inp[i] = head.data;
          end
        end
        `CMD_ALL_BOTH: begin
          for (int i = 0; i < 8; i++) begin
            d.inp[i] = head.data;
            d.dac[i] = head.data;
          end
        end
        `CMD_SW_RST: begin
          for (int i = 0; i < 8; i++) begin
            d.inp[i] = `CODE_RESET;
            d.dac[i] = `CODE_RESET;
          end
          d.pd = `PD_RESET;
          d.mask = `MASK_RESET;
        end
        default: begin
          d.pd = q.pd;
        end
      endcase
    end
    if (d.wp != q.wp && !(pop && !ld_fall)) begin
      d.fc = q.fc + 1'b1;
    end else if (d.wp == q.wp && pop) begin
      d.fc = q.fc - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  assign sda_out = q.sda_o;
  assign sda_oe_out = q.oe;
  assign dac_code_out = q.dac;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pwrdn_mode_hi_out[i] = q.pd[2*i+1];
      pwrdn_mode_lo_out[i] = q.pd[2*i];
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  AST_ADDR_MATCH: assert property ($rose(q.st == ST_ACKA) |->
    $past(q.sh[7:1]) == {`SLAVE_ADDR_HI, $past(q.strap)})
    else $error("acknowledged a foreign address");
  AST_ACK_LOW: assert property ($rose(q.st == ST_ACKA) |-> q.oe)
    else $error("address acknowledge not driven");
  AST_SKIP_FREE: assert property (q.st == ST_SKIP |-> !q.oe)
    else $error("sda driven after address mismatch");
  // Channels whose DAC register moves this cycle; works for any mask, not only all-zeros
  logic [7:0] dac_moved;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dac_moved[i] = (d.dac[i] != q.dac[i]);
    end
  end

  AST_SDA_SCL_LOW: assert property ($changed(q.oe) && !start && !stop |->
    !q.s3.scl)
    else $error("sda changed while scl high");
  AST_WR_UPD: assert property (pop && !ld_fall && head.command_code == `CMD_WR_UPD
    && !head.chan[3] |=> q.dac[$past(head.chan[2:0])] == $past(head.data))
    else $error("write-and-update missed the DAC register");
  AST_WR_IN_HOLD: assert property (pop && !ld_fall && head.command_code == `CMD_WR_IN
    && q.s2.load_strobe_n |=> q.dac == $past(q.dac))
    else $error("write-input touched a DAC register");
  AST_PWRDN: assert property (pop && !ld_fall && head.command_code == `CMD_PWRDN
    |=> q.pd == $past(head.data) && q.dac == $past(q.dac))
    else $error("power-down mode wrong or DAC register changed");
  AST_LD_FALL: assert property (ld_fall && q.mask == `MASK_RESET
    |=> q.dac == $past(q.inp))
    else $error("strobe edge did not load DAC registers");
  AST_MASKED: assert property (ld_fall |-> (dac_moved & q.mask) == 8'h00)
    else $error("masked channel followed the strobe");
  AST_WRAP: assert property (q.st == ST_RD && scl_f && q.cnt == `BITS_PER_BYTE
    && q.lo && q.ptr == 3'h7 |=> q.ptr == `CHAN_ZERO)
    else $error("readback pointer did not wrap");

  COV_WRITE: cover property (pop && head.command_code == `CMD_WR_IN);
  COV_READ: cover property (q.st == ST_ACKR ##[1:400] q.st == ST_SKIP);
  COV_FULL: cover property (full);
  COV_STROBE: cover property (ld_fall && q.fc != '0);

endmodule // dac_cmd_port
`default_nettype wire

// ===== dac_port_consts.svh
// Constants for the eight-channel DAC serial command port
//
// Behaviour
// - Write-and-update loads DAC register regardless of strobe
// - Slave address is 00011 plus two strap bits
// - Grounded strap gives 0, supply gives 1
// - Matching address acknowledged on ninth clock
// - Each byte is eight bits plus acknowledge
// - SDA changes only while SCL is low
// - Write is address, command, high, low, stop
// - Readback: command write, repeated start, read
// - Multi-channel readback selection returns channel zero
// - Readback sends MSB first, then next channels
// - Readback pointer wraps from channel seven to zero
// - Power-down takes two mode bits per channel
// - Modes: normal, 1k to ground, tristate
// - Power-down keeps DAC registers and accepts updates
// - Each channel has input and DAC stages
// - Strobe low: write-input also loads DAC register
// - Strobe falling edge copies input to DAC
// - Frame is command, channel, 16-bit data
// - Write-input with strobe high changes only the input register
// - Update copies input register into DAC register
// - Masked channels ignore the load strobe
`ifndef DAC_PORT_CONSTS_SVH
`define DAC_PORT_CONSTS_SVH

// ----------------------------------------------------------
// Bus framing
// ----------------------------------------------------------
`define SLAVE_ADDR_HI 5'h03
`define BITS_PER_BYTE 4'h8
`define FIRST_TX_BIT 4'h1
`define BYTE_CMD 2'h0
`define BYTE_HIGH 2'h1
`define BYTE_LOW 2'h2
`define BYTE_EXTRA 2'h3

// ----------------------------------------------------------
// Command codes
// ----------------------------------------------------------
`define CMD_WR_IN 4'h1
`define CMD_UPDATE 4'h2
`define CMD_WR_UPD 4'h3
`define CMD_PWRDN 4'h4
`define CMD_MASK 4'h5
`define CMD_SW_RST 4'h6
`define CMD_ALL_IN 4'hA
`define CMD_ALL_BOTH 4'hB

// ----------------------------------------------------------
// Reset values
// ----------------------------------------------------------
`define CODE_RESET 16'h0000
`define PD_RESET 16'h0000
`define MASK_RESET 8'h00
`define CHAN_ZERO 3'h0

`endif

// ===== dac_port_pkg.sv
// Types shared by the DAC serial command port
`default_nettype none
package dac_port_pkg;

  // Pins arriving from the board, all asynchronous to clk_sys_in
  typedef struct packed {
    logic scl;
    logic sda;
    logic load_strobe_n;
    logic addr_strap_high;
    logic addr_strap_low;
  } pins_t;

  // One received command frame, most significant field first
  typedef struct packed {
    logic [3:0] command_code;
    logic [3:0] chan;
    logic [15:0] data;
  } frame_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ACKA = 8'h04,
    ST_WR = 8'h08,
    ST_ACKW = 8'h10,
    ST_RD = 8'h20,
    ST_ACKR = 8'h40,
    ST_SKIP = 8'h80
  } bus_st_t;

endpackage
`default_nettype wire

// ===== i2c_master_model.sv
// Two-wire bus master model driving the clock and a pulled-up data wire
`default_nettype none
module i2c_master_model (
  // Clock
  input wire logic clk_sys_in,
  // Slave drive
  input wire logic slave_sda_in,
  input wire logic slave_oe_in,
  // Bus wires
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q = 1'b1;
  logic drv_q = 1'b1;
  // Pull-up: a wire that nobody pulls low reads high
  assign sda_out = drv_q & (slave_sda_in | ~slave_oe_in);
  assign scl_out = scl_q;
  // ----------------------------------------------------------
  // Bus phases, a quarter SCL period each
  // ----------------------------------------------------------
  task automatic q();
    repeat (4) @(posedge clk_sys_in);
  endtask
  task automatic step(input logic c, input logic d);
    scl_q <= c;
    drv_q <= d;
    q();
  endtask
  // Serves as first and repeated start; SCL stands high when idle
  task automatic bus_start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic bus_stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  // Data only moves while SCL is low
  task automatic bit_xfer(input logic b, output logic r);
    step(1'b0, b);
    step(1'b1, b);
    r = sda_out;
    step(1'b1, b);
    step(1'b0, b);
  endtask
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(last, r);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// ===== tb_dac_cmd_port.sv
// Self-checking bench for the DAC serial command port
`include "dac_port_consts.svh"
`default_nettype none
module tb_dac_cmd_port;
  timeunit 1ns;
  timeprecision 1ns;
  import dac_port_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic ldn = 1'b1;
  logic [1:0] strap = 2'h0;
  logic scl, sda, sda_o, sda_oe;
  logic [7:0][15:0] code;
  logic [7:0] pd_hi, pd_lo;
  pins_t pins;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  assign pins = '{scl: scl, sda: sda, load_strobe_n: ldn, addr_strap_high: strap[1],
                  addr_strap_low: strap[0]};
  dac_cmd_port dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .pins_in(pins),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .dac_code_out(code),
    .pwrdn_mode_hi_out(pd_hi), .pwrdn_mode_lo_out(pd_lo));
  i2c_master_model bfm (.clk_sys_in(clk_sys_in), .slave_sda_in(sda_o),
    .slave_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic [6:0] me();
    return {`SLAVE_ADDR_HI, strap};
  endfunction
  // Every byte of a foreign frame must go unanswered
  task automatic frame(input logic [6:0] ad, input logic [3:0] c, input logic [3:0] ch,
                       input logic [15:0] d, input logic ok);
    logic a;
    logic [7:0] b [4];
    b = '{{ad, 1'b0}, {c, ch}, d[15:8], d[7:0]};
    bfm.bus_start();
    foreach (b[i]) begin
      bfm.byte_w(b[i], a);
      chk({15'h0000, a}, {15'h0000, ok});
    end
    bfm.bus_stop();
    bfm.q();
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_address();
    for (int s = 0; s < 4; s++) begin
      strap <= 2'(s);
      @(posedge clk_sys_in);
      frame(me(), `CMD_WR_UPD, 4'h0, 16'(s), 1'b1);
      chk(code[0], 16'(s));
      frame({`SLAVE_ADDR_HI, ~strap}, `CMD_WR_UPD, 4'h0, 16'hFFFF, 1'b0);
      chk(code[0], 16'(s));
    end
  endtask
  task automatic t_strobe();
    frame(me(), `CMD_WR_IN, 4'h5, 16'hA5A5, 1'b1);
    chk(code[5], 16'h0000);
    ldn <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk(code[5], 16'hA5A5);
    frame(me(), `CMD_WR_IN, 4'h6, 16'h1234, 1'b1);
    chk(code[6], 16'h1234);
    ldn <= 1'b1;
    frame(me(), `CMD_MASK, 4'h0, 16'h0020, 1'b1);
    frame(me(), `CMD_WR_IN, 4'h5, 16'h5A5A, 1'b1);
    ldn <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    chk(code[5], 16'hA5A5);
    ldn <= 1'b1;
    frame(me(), `CMD_UPDATE, 4'h5, 16'h0000, 1'b1);
    chk(code[5], 16'h5A5A);
  endtask
  task automatic t_pwrdn();
    frame(me(), `CMD_PWRDN, 4'h0, 16'hC001, 1'b1);
    chk({8'h00, pd_hi}, 16'h0080);
    chk({8'h00, pd_lo}, 16'h0081);
    chk(code[5], 16'h5A5A);
    frame(me(), `CMD_WR_UPD, 4'h7, 16'hBEEF, 1'b1);
    chk(code[7], 16'hBEEF);
  endtask
  // Pointer set by a lone command byte, then two channels read back
  task automatic t_read(input logic [3:0] ch, input logic [15:0] e0, input logic [15:0] e1);
    logic a;
    logic [7:0] d [4];
    bfm.bus_start();
    bfm.byte_w({me(), 1'b0}, a);
    bfm.byte_w({`CMD_WR_IN, ch}, a);
    chk({15'h0000, a}, 16'h0001);
    bfm.bus_start();
    bfm.byte_w({me(), 1'b1}, a);
    chk({15'h0000, a}, 16'h0001);
    foreach (d[i]) begin
      bfm.byte_r(i == 3, d[i]);
    end
    bfm.bus_stop();
    chk({d[0], d[1]}, e0);
    chk({d[2], d[3]}, e1);
  endtask
  // Broadcast writes, then a software reset whose surplus fourth byte after the address is refused
  task automatic t_broadcast();
    logic a;
    frame(me(), `CMD_ALL_IN, 4'h0, 16'h1111, 1'b1);
    chk(code[1], 16'h0000);
    frame(me(), `CMD_ALL_BOTH, 4'h0, 16'h2222, 1'b1);
    chk(code[1], 16'h2222);
    chk(code[5], 16'h2222);
    bfm.bus_start();
    bfm.byte_w({me(), 1'b0}, a);
    bfm.byte_w({`CMD_SW_RST, 4'h0}, a);
    bfm.byte_w(8'h00, a);
    bfm.byte_w(8'h00, a);
    bfm.byte_w(8'h00, a);
    chk({15'h0000, a}, 16'h0000);
    bfm.bus_stop();
    bfm.q();
    chk(code[1], 16'h0000);
    chk({pd_hi, pd_lo}, 16'h0000);
  endtask
  // ----------------------------------------------------------
  // Sequence and hang guard
  // ----------------------------------------------------------
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    t_address();
    t_strobe();
    t_pwrdn();
    t_read(4'h7, 16'hBEEF, 16'h0003);
    t_read(4'hF, 16'h0003, 16'h0000);
    t_broadcast();
    complete_run();
  end
endmodule // tb_dac_cmd_port
`default_nettype wire
